/* File: hw/synth_pkg.sv */
// Purpose: shared constants of the synthesizer control block
// Assumes: registers A..D at indexes 0..3, status read without index
// Notes: the status register has no index, it is the only read target
package synth_pkg;
  localparam int REG_N = 4;
  localparam logic [1:0] PTR_D = 2'h3;
  localparam logic [7:0] RST_A = 8'h0E;
  localparam logic [7:0] RST_B = 8'hA5;
  localparam logic [7:0] RST_C = 8'h38;
  localparam logic [7:0] RST_D = 8'h80;
  // register A fields
  localparam int A_SLEEP = 7;
  localparam int A_PUMP = 5;
  localparam int A_REF_MSB = 3;
  // register B fields
  localparam int B_INV = 4;
  localparam int B_VCO2 = 3;
  localparam int B_VCO1 = 2;
  localparam int B_MAIN_MSB = 1;
  // index byte fields
  localparam int SUB_MASK = 4;
  localparam int SUB_INC = 3;
  localparam int SUB_PTR_MSB = 1;
  // status byte fields
  localparam int ST_NOW = 4;
  localparam int ST_LOCK = 2;
  localparam int ST_DIP = 1;
  localparam int ST_MASK = 0;
  // bus address, upper six bits
  localparam logic [5:0] ADDR_FIXED = 6'h31;
  // dividers
  localparam int MAIN_W = 18;
  localparam int REF_W = 11;
  localparam logic [17:0] MAIN_MIN = 18'h00800;
  localparam logic [10:0] REF_RATIO [16] = '{
    11'h080, 11'h0A0, 11'h0C0, 11'h0F0,
    11'h100, 11'h140, 11'h180, 11'h1E0,
    11'h200, 11'h280, 11'h300, 11'h3C0,
    11'h400, 11'h500, 11'h600, 11'h780};
  // lock detector timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int ERR_LIMIT_NS = 200;
  localparam int ERR_CYC = (ERR_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] ERR_CYC_W = 6'(ERR_CYC);
  localparam logic [2:0] GOOD_REFS = 3'h6;
endpackage

/* File: hw/serial_bus_if.sv */
// Purpose: byte level carrier between bus engine and register core
// Assumes: scl and sda already synchronised to core_clk
// Notes: byte_valid and read_done are one-cycle pulses
`timescale 1ns/1ns
interface serial_bus_if;
  logic scl;
  logic sda;
  logic addr_bit;
  logic [7:0] status;
  logic byte_valid;
  logic byte_is_sub;
  logic [7:0] byte_data;
  logic read_done;
  logic sda_oe;
  modport slave(input scl, sda, addr_bit, status,
    output byte_valid, byte_is_sub, byte_data, read_done, sda_oe);
  modport core(output scl, sda, addr_bit, status,
    input byte_valid, byte_is_sub, byte_data, read_done, sda_oe);
endinterface

/* File: hw/two_wire_slave.sv */
// Purpose: two-wire bus slave, byte framing, ack and status read
// Assumes: bus clock far below core_clk, inputs synchronised
// Notes: one status byte per read; further reads need a new start
`timescale 1ns/1ns
module two_wire_slave (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // byte side
  serial_bus_if.slave bus
);
  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_ADDR = 9'h002, S_ACK_A = 9'h004,
    S_SUB = 9'h008, S_ACK_S = 9'h010, S_WDATA = 9'h020,
    S_ACK_D = 9'h040, S_RDATA = 9'h080, S_RACK = 9'h100
  } link_state_e;
  link_state_e state;
  logic scl_d, sda_d, rw;
  logic [7:0] sh;
  logic [3:0] cnt;
  wire start = bus.scl & scl_d & sda_d & ~bus.sda;
  wire stop = bus.scl & scl_d & ~sda_d & bus.sda;
  wire rise = bus.scl & ~scl_d;
  wire fall = ~bus.scl & scl_d;
  wire full = cnt == 4'h8;
  wire addr_hit = sh[7:1] == {synth_pkg::ADDR_FIXED, bus.addr_bit};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      rw <= 1'b0;
      sh <= 8'h00;
      cnt <= 4'h0;
      bus.byte_valid <= 1'b0;
      bus.byte_is_sub <= 1'b0;
      bus.byte_data <= 8'h00;
      bus.read_done <= 1'b0;
      bus.sda_oe <= 1'b0;
    end else begin
      scl_d <= bus.scl;
      sda_d <= bus.sda;
      bus.byte_valid <= 1'b0;
      bus.read_done <= 1'b0;
      if (start) begin
        state <= S_ADDR;
        cnt <= 4'h0;
        bus.sda_oe <= 1'b0;
      end else if (stop) begin
        state <= S_IDLE;
        bus.sda_oe <= 1'b0;
      end else begin
        unique case (state)
          S_IDLE: ;
          S_ADDR, S_SUB, S_WDATA: begin
            if (rise) begin
              sh <= {sh[6:0], bus.sda};
              cnt <= cnt + 4'h1;
            end else if (fall && full) begin
              if (state == S_ADDR) begin
                // foreign address: stay silent until next start
                state <= addr_hit ? S_ACK_A : S_IDLE;
                bus.sda_oe <= addr_hit;
                rw <= sh[0];
              end else begin
                // index byte comes first, then data
                bus.byte_valid <= 1'b1;
                bus.byte_is_sub <= state == S_SUB;
                bus.byte_data <= sh;
                bus.sda_oe <= 1'b1;
                state <= state == S_SUB ? S_ACK_S : S_ACK_D;
              end
            end
          end
          S_ACK_A: begin
            if (fall) begin
              cnt <= 4'h0;
              if (rw) begin
                // status goes out right after the address
                bus.sda_oe <= ~bus.status[7];
                sh <= {bus.status[6:0], 1'b0};
                state <= S_RDATA;
              end else begin
                bus.sda_oe <= 1'b0;
                state <= S_SUB;
              end
            end
          end
          S_ACK_S, S_ACK_D: begin
            if (fall) begin
              bus.sda_oe <= 1'b0;
              cnt <= 4'h0;
              state <= S_WDATA;
            end
          end
          S_RDATA: begin
            if (rise) begin
              cnt <= cnt + 4'h1;
            end else if (fall) begin
              if (full) begin
                bus.sda_oe <= 1'b0;
                state <= S_RACK;
              end else begin
                bus.sda_oe <= ~sh[7];
                sh <= {sh[6:0], 1'b0};
              end
            end
          end
          S_RACK: begin
            if (rise) begin
              bus.read_done <= 1'b1;
              state <= S_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule

/* File: hw/cycle_divider.sv */
// Purpose: divide a stream of ticks by a programmable ratio
// Assumes: ratio of at least 2, tick at most one cycle wide
// Notes: held at zero while run is low
`timescale 1ns/1ns
module cycle_divider #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // control
  input wire logic run,
  input wire logic tick,
  input wire logic [W-1:0] ratio,
  // output
  output logic pulse
);
  logic [W-1:0] cnt;
  wire wrap = cnt >= ratio - W'(1);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      pulse <= 1'b0;
    end else begin
      pulse <= run & tick & wrap;
      if (!run) begin
        cnt <= '0;
      end else if (tick) begin
        cnt <= wrap ? '0 : cnt + W'(1);
      end
    end
  end
endmodule

/* File: hw/synth_serial_control_regs.sv */
// Purpose: serial control, dividers and lock logic of a channel synthesizer
// Assumes: ref_clk_in is the oscillator, rf_div_in the prescaled RF
// Notes: open-drain pins drive low while their enable is high
// How it works
// - Four-bit reference code picks one of sixteen ratios, 128 to 1920.
// - Normal polarity: slower reference gives DOWN, faster gives UP.
// - Inverted polarity swaps UP and DOWN; pump idle when equal.
// - Write: address, index byte, then any number of data bytes.
// - First data byte goes to register chosen by index bits 1..0.
// - Auto-increment set: pointer advances after every data byte.
// - Auto-increment clear: every data byte hits the same register.
// - Index: pointer bits 1..0, increment bit 3, mask bit 4.
// - Mask bit set keeps the alarm pin released.
// - Answer only when address top six bits are 110001.
// - Seventh address bit is the inverse of the select input.
// - Status read: address with read bit, then one status byte.
// - Lock loss or supply dip pulls alarm low and latches it.
// - A completed status read releases the alarm latch.
// - Status: bit4 lock now, bit2 lock latched, bit1 dip, bit0 mask.
// - Setup controls live in registers A and B.
// - Sleep bit idles dividers and pump; bus keeps working.
// - 18-bit ratio buffered, loaded after D byte at divider output, or at once in sleep.
// - Ratio below 2048 is used plus 2048.
// - Lock lost above 200 ns error, cleared after 6 good references.
// - Register B drives VCO switches; first is low while unlocked.
`timescale 1ns/1ns
module synth_serial_control_regs (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // straps and monitors
  input wire logic address_select_input,
  input wire logic supply_dip_in,
  // timing inputs
  input wire logic ref_clk_in,
  input wire logic rf_div_in,
  // alarm pin, open drain
  output logic alarm_output,
  output logic alarm_output_oe,
  // vco switches
  output logic vco_switch_first,
  output logic vco_switch_second,
  // charge pump
  output logic pump_up,
  output logic pump_down,
  output logic pump_oe,
  output logic pump_current_select,
  // state seen from outside
  output logic sleep_active,
  output logic [10:0] ref_ratio,
  output logic [17:0] main_ratio
);
  localparam int PIN_N = 6;
  localparam int P_SCL = 0;
  localparam int P_SDA = 1;
  localparam int P_SEL = 2;
  localparam int P_DIP = 3;
  localparam int P_REF = 4;
  localparam int P_RF = 5;

  // pin synchronisers, stage one is read by stage two only
  logic [PIN_N-1:0] sync1, sync2, sync3;
  wire [PIN_N-1:0] pins = {rf_div_in, ref_clk_in, supply_dip_in,
    address_select_input, sda_in, scl_in};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= 6'h03;
      sync2 <= 6'h03;
      sync3 <= 6'h03;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  wire ref_tick = sync2[P_REF] & ~sync3[P_REF];
  wire rf_tick = sync2[P_RF] & ~sync3[P_RF];
  wire dip_now = sync2[P_DIP];

  // register file and index state
  logic [7:0] regs [synth_pkg::REG_N];
  logic [1:0] ptr;
  logic autoinc;
  logic mask;
  logic ratio_pending;
  logic lock_now, lock_latched, dip_latched, alarm_latch;

  serial_bus_if bus ();

  assign bus.scl = sync2[P_SCL];
  assign bus.sda = sync2[P_SDA];
  assign bus.addr_bit = ~sync2[P_SEL];
  assign bus.status = {3'h0, lock_now, 1'b0, lock_latched, dip_latched,
    mask};

  two_wire_slave u_slave (
    .core_clk(core_clk),
    .resetn(resetn),
    .bus(bus)
  );

  wire wr_sub = bus.byte_valid & bus.byte_is_sub;
  wire wr_data = bus.byte_valid & ~bus.byte_is_sub;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regs[0] <= synth_pkg::RST_A;
      regs[1] <= synth_pkg::RST_B;
      regs[2] <= synth_pkg::RST_C;
      regs[3] <= synth_pkg::RST_D;
      ptr <= 2'h0;
      autoinc <= 1'b0;
      mask <= 1'b0;
    end else if (wr_sub) begin
      // unused index bits 7..5 and 2 are dropped
      ptr <= bus.byte_data[synth_pkg::SUB_PTR_MSB:0];
      autoinc <= bus.byte_data[synth_pkg::SUB_INC];
      mask <= bus.byte_data[synth_pkg::SUB_MASK];
    end else if (wr_data) begin
      regs[ptr] <= bus.byte_data;
      // two-bit pointer rolls D to A by itself
      if (autoinc) begin
        ptr <= ptr + 2'h1;
      end
      // without autoinc ptr is left alone
    end
  end

  // setup fields from A and B, main ratio from B, C and D
  wire [7:0] reg_a = regs[0];
  wire [7:0] reg_b = regs[1];
  wire sleep = reg_a[synth_pkg::A_SLEEP];
  wire invert = reg_b[synth_pkg::B_INV];
  wire [3:0] ref_code = reg_a[synth_pkg::A_REF_MSB:0];
  wire [10:0] ref_sel = synth_pkg::REF_RATIO[ref_code];
  wire [17:0] main_buf = {reg_b[synth_pkg::B_MAIN_MSB:0], regs[2], regs[3]};
  wire [17:0] main_eff = main_buf < synth_pkg::MAIN_MIN ?
    main_buf + synth_pkg::MAIN_MIN : main_buf;

  // ratio buffer: take effect at the divider boundary, or at once in sleep
  logic ref_pulse, var_pulse;
  logic [17:0] main_active;
  wire d_written = wr_data & (ptr == synth_pkg::PTR_D);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ratio_pending <= 1'b0;
      main_active <= {synth_pkg::RST_B[synth_pkg::B_MAIN_MSB:0],
        synth_pkg::RST_C, synth_pkg::RST_D};
    end else begin
      // a D write in the load cycle keeps the flag
      if (d_written) begin
        ratio_pending <= 1'b1;
      end else if (ratio_pending && (var_pulse || sleep)) begin
        ratio_pending <= 1'b0;
      end
      if (ratio_pending && (var_pulse || sleep)) begin
        main_active <= main_eff;
      end
    end
  end

  cycle_divider #(.W(synth_pkg::REF_W)) u_ref_div (
    .core_clk(core_clk),
    .resetn(resetn),
    .run(~sleep),
    .tick(ref_tick),
    .ratio(ref_sel),
    .pulse(ref_pulse)
  );

  cycle_divider #(.W(synth_pkg::MAIN_W)) u_main_div (
    .core_clk(core_clk),
    .resetn(resetn),
    .run(~sleep),
    .tick(rf_tick),
    .ratio(main_active),
    .pulse(var_pulse)
  );

  // phase-frequency detector, the pair clears when both are up
  logic lead_ref, lead_var;
  wire both = (lead_ref | ref_pulse) & (lead_var | var_pulse);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lead_ref <= 1'b0;
      lead_var <= 1'b0;
    end else if (sleep || both) begin
      lead_ref <= 1'b0;
      lead_var <= 1'b0;
    end else begin
      lead_ref <= lead_ref | ref_pulse;
      lead_var <= lead_var | var_pulse;
    end
  end

  wire next_up = invert ? lead_var : lead_ref;
  wire next_down = invert ? lead_ref : lead_var;
  wire err_active = lead_ref | lead_var;

  // lock detector: error length counted in core cycles
  logic [5:0] err_cnt;
  logic [2:0] good_cnt;
  logic period_bad;
  wire err_long = err_cnt >= synth_pkg::ERR_CYC_W;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      err_cnt <= 6'h00;
      good_cnt <= 3'h0;
      period_bad <= 1'b0;
      lock_now <= 1'b0;
    end else begin
      if (!err_active) begin
        err_cnt <= 6'h00;
      end else if (!err_long) begin
        err_cnt <= err_cnt + 6'h01;
      end
      if (err_long) begin
        lock_now <= 1'b1;
        good_cnt <= 3'h0;
        period_bad <= 1'b1;
      end else if (ref_pulse) begin
        period_bad <= 1'b0;
        if (period_bad) begin
          good_cnt <= 3'h0;
        end else if (good_cnt + 3'h1 >= synth_pkg::GOOD_REFS) begin
          good_cnt <= 3'h0;
          lock_now <= 1'b0;
        end else if (lock_now) begin
          good_cnt <= good_cnt + 3'h1;
        end
      end
    end
  end

  // alarm and latched status; a new event beats a read clear
  logic lock_now_d;
  wire lock_rise = lock_now & ~lock_now_d;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lock_now_d <= 1'b0;
      lock_latched <= 1'b0;
      dip_latched <= 1'b0;
      alarm_latch <= 1'b0;
    end else begin
      lock_now_d <= lock_now;
      if (lock_now) begin
        lock_latched <= 1'b1;
      end else if (bus.read_done) begin
        lock_latched <= 1'b0;
      end
      if (dip_now) begin
        dip_latched <= 1'b1;
      end else if (bus.read_done) begin
        dip_latched <= 1'b0;
      end
      if (lock_rise || dip_now) begin
        alarm_latch <= 1'b1;
      end else if (bus.read_done) begin
        alarm_latch <= 1'b0;
      end
    end
  end

  // output stage, every pin from a flop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      alarm_output <= 1'b0;
      alarm_output_oe <= 1'b0;
      vco_switch_first <= 1'b0;
      vco_switch_second <= 1'b0;
      pump_up <= 1'b0;
      pump_down <= 1'b0;
      pump_oe <= 1'b0;
      pump_current_select <= 1'b0;
      sleep_active <= 1'b0;
      ref_ratio <= 11'h000;
      main_ratio <= 18'h00000;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= bus.sda_oe;
      alarm_output <= 1'b0;
      alarm_output_oe <= alarm_latch & ~mask;
      vco_switch_first <= reg_b[synth_pkg::B_VCO1] & ~lock_now;
      vco_switch_second <= reg_b[synth_pkg::B_VCO2];
      pump_up <= next_up;
      pump_down <= next_down;
      // pump floats when neither side leads
      pump_oe <= next_up | next_down;
      pump_current_select <= reg_a[synth_pkg::A_PUMP];
      sleep_active <= sleep;
      ref_ratio <= ref_sel;
      main_ratio <= main_active;
    end
  end
endmodule

/* File: test/synth_ctrl_properties.sv */
// Purpose: port level checks of the synthesizer control block
// Assumes: bus master keeps each scl phase at least 6 core cycles
// Notes: bound to every instance of the top module
`timescale 1ns/1ns
module synth_ctrl_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // bus and monitors
  input wire logic scl_in,
  input wire logic supply_dip_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // outputs
  input wire logic alarm_output,
  input wire logic alarm_output_oe,
  input wire logic pump_up,
  input wire logic pump_down,
  input wire logic pump_oe,
  input wire logic sleep_active,
  input wire logic [10:0] ref_ratio,
  input wire logic [17:0] main_ratio
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  a_ref_range: assert property (
    $past(resetn) |-> ref_ratio >= 11'h080 && ref_ratio <= 11'h780)
    else $error("reference ratio outside its table");
  a_pump_exclusive: assert property (
    !(pump_up && pump_down))
    else $error("pump up and down together");
  a_pump_idle_hiz: assert property (
    !(pump_up || pump_down) [*2] |-> !pump_oe)
    else $error("pump driven while comparator idle");
  a_sleep_quiet: assert property (
    sleep_active [*3] |-> !pump_up && !pump_down)
    else $error("pump active in sleep");
  a_main_floor: assert property (
    $past(resetn) |-> main_ratio >= 18'h00800)
    else $error("main ratio below its floor");
  // the block acts on synchronised scl, so allow the sync lag
  a_ref_on_write: assert property (
    $past(resetn, 2) && $changed(ref_ratio) |->
      !scl_in || !$past(scl_in, 3))
    else $error("reference ratio changed outside a byte end");
  a_ack_on_low: assert property (
    $changed(sda_oe) |-> !scl_in || !$past(scl_in, 3))
    else $error("sda moved while scl high");
  a_main_in_sleep: assert property (
    sleep_active && $past(sleep_active) && $changed(main_ratio) |->
      !scl_in || !$past(scl_in, 3))
    else $error("main ratio loaded outside a byte end");
  // a dip takes four edges from pin to alarm enable, so look that far back
  a_alarm_set_wins: assert property (
    $fell(alarm_output_oe) |-> !$past(supply_dip_in, 4))
    else $error("alarm released while dip present");
  a_open_drain: assert property (
    !sda_out && !alarm_output)
    else $error("open drain pin driven high");
  cover property ($rose(alarm_output_oe));
  cover property ($fell(alarm_output_oe));
  cover property ($rose(pump_up));
  cover property ($rose(pump_down));
endmodule
bind synth_serial_control_regs synth_ctrl_properties u_props (
  .core_clk, .resetn, .scl_in, .supply_dip_in, .sda_out, .sda_oe,
  .alarm_output, .alarm_output_oe, .pump_up, .pump_down, .pump_oe,
  .sleep_active, .ref_ratio, .main_ratio);

/* File: test/bus_master_model.sv */
// Purpose: two-wire bus master standing in for the host controller
// Assumes: sda_line is the resolved wire with a pull-up
// Notes: 48 ns bit time, data moves mid low phase
`timescale 1ns/1ns
module bus_master_model (
  // clock
  input wire logic core_clk,
  // bus wires
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one bit: data set mid low, wire sampled at end of high
  task automatic bit_io(input logic b, output logic seen);
    wait_cyc(3);
    sda_pull = ~b;
    wait_cyc(3);
    scl = 1'b1;
    wait_cyc(6);
    seen = sda_line;
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] b, output logic [7:0] got,
      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], got[i]);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic stop();
    wait_cyc(3);
    sda_pull = 1'b1;
    wait_cyc(3);
    scl = 1'b1;
    wait_cyc(6);
    sda_pull = 1'b0;
    wait_cyc(6);
  endtask
  // address, index byte, then any number of data bytes
  task automatic write_frame(input logic [7:0] addr,
      input logic [7:0] sub, input logic [7:0] q[$], output logic ok);
    logic [7:0] got;
    logic a;
    sda_pull = 1'b1;
    wait_cyc(6);
    scl = 1'b0;
    xfer(addr, got, ok);
    if (ok) begin
      xfer(sub, got, a);
      foreach (q[i]) begin
        xfer(q[i], got, a);
      end
    end
    stop();
  endtask
  // read address then one byte, no index, master nacks it
  task automatic read_frame(input logic [7:0] addr,
      output logic [7:0] st, output logic ok);
    logic a;
    sda_pull = 1'b1;
    wait_cyc(6);
    scl = 1'b0;
    xfer(addr, st, ok);
    if (ok) begin
      xfer(8'hFF, st, a);
    end
    stop();
  endtask
endmodule

/* File: test/synth_serial_control_regs_tb.sv */
// Purpose: self-checking bench of the synthesizer control block
// Assumes: host model drives the bus, inputs move 1 ns after clock
// Notes: ratio loads are watched in sleep, where they apply at once
`timescale 1ns/1ns
module synth_serial_control_regs_tb;
  logic core_clk, resetn, scl_in, sda_in, sda_out, sda_oe, sda_pull;
  logic address_select_input, supply_dip_in, ref_clk_in, rf_div_in;
  logic alarm_output, alarm_output_oe, vco_switch_first;
  logic vco_switch_second, pump_up, pump_down, pump_oe;
  logic pump_current_select, sleep_active, ok;
  logic [10:0] ref_ratio;
  logic [17:0] main_ratio;
  logic [7:0] q[$];
  logic [7:0] bad;
  int regs[4];
  int main_exp, err_count, n_tests, cycles;
  assign sda_in = ~(sda_pull | sda_oe);
  synth_serial_control_regs u_dut (.core_clk, .resetn, .scl_in, .sda_in,
    .sda_out, .sda_oe, .address_select_input, .supply_dip_in,
    .ref_clk_in, .rf_div_in, .alarm_output, .alarm_output_oe,
    .vco_switch_first, .vco_switch_second, .pump_up, .pump_down,
    .pump_oe, .pump_current_select, .sleep_active, .ref_ratio,
    .main_ratio);
  bus_master_model u_host (.core_clk, .sda_line(sda_in), .scl(scl_in),
    .sda_pull);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 50000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  function automatic int ratio_of(input int c);
    int base[4] = '{128, 160, 192, 240};
    return base[c % 4] << (c / 4);
  endfunction
  function automatic int main_of();
    int m;
    m = (regs[1] % 4) * 65536 + regs[2] * 256 + regs[3];
    return m < 2048 ? m + 2048 : m;
  endfunction
  function automatic logic [7:0] addr(input logic rw);
    return {6'h31, ~address_select_input, rw};
  endfunction
  task automatic do_reset();
    resetn = 1'b0;
    wait_cyc(10);
    resetn = 1'b1;
    regs = '{8'h0E, 8'hA5, 8'h38, 8'h80};
    main_exp = 80000;
    wait_cyc(3);
  endtask
  task automatic wr(input int ptr, input int inc, input int mask,
      input logic [7:0] d[$]);
    int p;
    logic [7:0] sub;
    p = ptr;
    sub = 8'(mask * 16 + inc * 8 + ptr) | (8'($urandom) & 8'hE4);
    foreach (d[i]) begin
      regs[p] = d[i];
      if (p == 3) main_exp = main_of();
      if (inc != 0) p = (p + 1) % 4;
    end
    u_host.write_frame(addr(1'b0), sub, d, ok);
    check(ok, 1);
    wait_cyc(6);
  endtask
  task automatic rd(input logic [7:0] exp);
    logic [7:0] st;
    u_host.read_frame(addr(1'b1), st, ok);
    check(ok, 1);
    check(st, exp);
    wait_cyc(6);
  endtask
  task automatic check_outs();
    check(sleep_active, regs[0] / 128);
    check(pump_current_select, regs[0] / 32 % 2);
    check(ref_ratio, ratio_of(regs[0] % 16));
    check(vco_switch_first, regs[1] / 4 % 2);
    check(vco_switch_second, regs[1] / 8 % 2);
    check(main_ratio, main_exp);
    check({sda_out, alarm_output}, 0);
  endtask
  initial begin
    {resetn, address_select_input, supply_dip_in} = 3'h0;
    {ref_clk_in, rf_div_in} = 2'h0;
    {err_count, n_tests, cycles} = '0;
    void'($urandom(97));
    do_reset();
    check_outs();
    $display("test presets done");
    // bit 7 kept set so the block sleeps and ratios load at once
    for (int i = 0; i < 8; i++) begin
      address_select_input = i[0];
      q = {};
      repeat (i == 7 ? 4 : 1 + $urandom % 4) q.push_back(8'($urandom) | 8'h80);
      // odd passes flip the select bit, even ones a fixed address bit
      bad = 8'h02 << (i % 2 == 1 ? 0 : 1 + $urandom % 6);
      u_host.write_frame(addr(1'b0) ^ bad, 8'h00, q, ok);
      check(ok, 0);
      wr(i % 4, i / 4, 0, q);
      check_outs();
    end
    for (int c = 0; c < 16; c++) begin
      q = {8'(8'h80 | c)};
      wr(0, 0, 0, q);
      check(ref_ratio, ratio_of(c));
    end
    q = {8'h80, 8'h07, 8'hFF};
    wr(1, 1, 0, q);
    check(main_ratio, 18'h00FFF);
    $display("test registers done");
    do_reset();
    q = {};
    wr(0, 0, 0, q);
    supply_dip_in = 1'b1;
    wait_cyc(10);
    supply_dip_in = 1'b0;
    wait_cyc(10);
    check(alarm_output_oe, 1);
    rd(8'h02);
    check(alarm_output_oe, 0);
    rd(8'h00);
    wr(0, 0, 1, q);
    supply_dip_in = 1'b1;
    wait_cyc(10);
    check(alarm_output_oe, 0);
    rd(8'h03);
    supply_dip_in = 1'b0;
    wait_cyc(10);
    rd(8'h03);
    rd(8'h01);
    $display("test alarm done");
    for (int m = 0; m < 4; m++) begin
      do_reset();
      q = {8'h80, 8'(8'hA4 | m % 2 * 16), 8'h00, 8'h00};
      wr(0, 1, 0, q);
      check(main_ratio, 18'h00800);
      q = {8'h00};
      wr(0, 0, 0, q);
      repeat (m / 2 == 1 ? 4400 : 600) begin
        if (m / 2 == 1) rf_div_in = ~rf_div_in;
        else ref_clk_in = ~ref_clk_in;
        wait_cyc(1);
      end
      check(pump_up, (m / 2) ^ (m % 2) ^ 1);
      check(pump_down, (m / 2) ^ (m % 2));
      check(pump_oe, 1);
      check(vco_switch_first, 0);
      check(alarm_output_oe, 1);
      rd(8'h14);
    end
    $display("test comparator done");
    tally_and_finish();
  end
endmodule
